// ### rtl/tcb_pkg.sv
`default_nettype none
package tcb_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] CH3_CCR_OFFSET = 8'h3C;
  localparam logic [7:0] CH4_CCR_OFFSET = 8'h40;
  localparam logic [7:0] PROT_OFFSET = 8'h44;
  localparam logic [7:0] CHCFG_OFFSET = 8'h48;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h4C;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h50;
  // compare field
  localparam int CMP_W = 20;
  localparam logic [19:0] CMP_RESET = 20'h0_0000;
  // protection register fields
  localparam int MOE_BIT = 15;
  localparam int AOE_BIT = 14;
  localparam int BKP_BIT = 13;
  localparam int BKE_BIT = 12;
  localparam int LOCK_LSB = 8;
  localparam logic [1:0] LOCK_NONE = 2'b00;
  // channel config register fields (per channel: 4 bits at 4*(ch-3))
  localparam int CFG_INPUT = 0;
  localparam int CFG_PRELOAD = 1;
  localparam int CFG_OE = 2;
  localparam int CFG_NOE = 3;
  // interrupt status bits
  localparam int IRQ_CAP3 = 0;
  localparam int IRQ_CAP4 = 1;
  localparam int IRQ_BREAK = 2;
  localparam int IRQ_W = 3;
endpackage
`default_nettype wire

// ### rtl/tcb_cmp_if.sv
`default_nettype none
interface tcb_cmp_if;
  logic [19:0] counter;
  logic update;
  logic capture;
  logic input_mode;
  logic preload_en;
  logic wr;
  logic [19:0] wdata;
  logic [19:0] value;
  logic [19:0] active;
  logic match;
  modport ctl (output counter, update, capture, input_mode, preload_en, wr, wdata,
               input value, active, match);
  modport chan (input counter, update, capture, input_mode, preload_en, wr, wdata,
                output value, active, match);
endinterface
`default_nettype wire

// ### rtl/tcb_channel.sv
`default_nettype none
module tcb_channel (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // channel bundle
  tcb_cmp_if.chan cmp
);
  logic [19:0] value_reg;
  logic [19:0] active_reg;
  logic match_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      value_reg <= tcb_pkg::CMP_RESET;
    end else if (cmp.input_mode) begin
      if (cmp.capture) begin
        value_reg <= cmp.counter;
      end
    end else if (cmp.wr) begin
      value_reg <= cmp.wdata;
    end
  end

  // shadow copy only moves on update when preload is on
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      active_reg <= tcb_pkg::CMP_RESET;
    end else if (!cmp.preload_en || cmp.update) begin
      active_reg <= (!cmp.preload_en && cmp.wr && !cmp.input_mode) ? cmp.wdata : value_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= !cmp.input_mode && (cmp.counter >= active_reg);
    end
  end

  assign cmp.value = value_reg;
  assign cmp.active = active_reg;
  assign cmp.match = match_reg;

  a_shadow_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmp.preload_en && $past(cmp.preload_en) && !$past(cmp.update) |-> $stable(active_reg))
    else $error("shadow changed without update");
  a_capture_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmp.input_mode && cmp.capture |=> value_reg == $past(cmp.counter))
    else $error("capture value not taken");
  a_input_nowrite: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmp.input_mode && !cmp.capture |=> $stable(value_reg))
    else $error("input-mode value changed");
  a_direct_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !cmp.input_mode && !cmp.preload_en && cmp.wr |=> active_reg == $past(cmp.wdata))
    else $error("direct write not active");
endmodule
`default_nettype wire

// ### rtl/tcb_timer_ch34.sv
// What this block does
// - ch3 input mode: capture counter, read-only
// - ch3 output mode: written value compared
// - shadow enabled: copy at update only
// - ch4 input mode: capture, writes ignored
// - ch4 output mode: written value compared
// - main enable set by software or hardware
// - break clears main enable synchronously
// - outputs driven only with channel enables
// - main enable low: outputs idle
// - auto enable sets main at update
// - auto enable writable only at lock 00
// - polarity bit: 0 low, 1 high
// - break enable gates pin and clock-fail
// - lock 00 means no protection
//
// The plain strobed port is this design's own decision.
`default_nettype none
module tcb_timer_ch34 (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // timer core
  input wire logic [19:0] counter_i,
  input wire logic update_i,
  input wire logic capture3_i,
  input wire logic capture4_i,
  // break sources
  input wire logic break_pin_i,
  input wire logic clock_failure_monitor_i,
  // channel pins
  output logic [1:0] channel_output_o,
  output logic [1:0] channel_complement_output_o,
  output logic [1:0] channel_output_oe_o,
  output logic [1:0] channel_complement_output_oe_o,
  // status
  output logic main_output_enable_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  tcb_cmp_if c3 ();
  tcb_cmp_if c4 ();

  logic main_output_enable_reg;
  logic auto_output_enable_reg;
  logic break_polarity_select_reg;
  logic break_inputs_enable_reg;
  logic [1:0] lock_reg;
  logic lock_written_reg;
  logic [7:0] chcfg_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [31:0] rdata_reg;
  logic [1:0] pin_sync1_reg;
  logic [1:0] pin_sync2_reg;
  logic break_active;
  logic break_active_d_reg;
  logic [1:0] out_reg;
  logic [1:0] outn_reg;
  logic [1:0] oe_reg;
  logic [1:0] noe_reg;
  logic irq_reg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic s);
    hit = s && (a == off);
  endfunction

  // status and compare fields are packed by hand in the read mux below
  if (tcb_pkg::IRQ_W != 3 || tcb_pkg::CMP_W != 20) begin : g_layout_check
    $error("field widths do not fit the register layout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // break pin and clock-fail are asynchronous; sync before use
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_sync1_reg <= 2'b00;
      pin_sync2_reg <= 2'b00;
    end else begin
      pin_sync1_reg <= {clock_failure_monitor_i, break_pin_i};
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // polarity and gate on the pin
  assign break_active = break_inputs_enable_reg &&
                        ((pin_sync2_reg[0] == break_polarity_select_reg) || pin_sync2_reg[1]);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      break_active_d_reg <= 1'b0;
    end else begin
      break_active_d_reg <= break_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel wiring
  assign c3.counter = counter_i;
  assign c3.update = update_i;
  assign c3.capture = capture3_i;
  assign c3.input_mode = chcfg_reg[tcb_pkg::CFG_INPUT];
  assign c3.preload_en = chcfg_reg[tcb_pkg::CFG_PRELOAD];
  assign c3.wr = hit(addr_i, tcb_pkg::CH3_CCR_OFFSET, wr_i);
  assign c3.wdata = wdata_i[19:0];
  assign c4.counter = counter_i;
  assign c4.update = update_i;
  assign c4.capture = capture4_i;
  assign c4.input_mode = chcfg_reg[4 + tcb_pkg::CFG_INPUT];
  assign c4.preload_en = chcfg_reg[4 + tcb_pkg::CFG_PRELOAD];
  assign c4.wr = hit(addr_i, tcb_pkg::CH4_CCR_OFFSET, wr_i);
  assign c4.wdata = wdata_i[19:0];

  tcb_channel u_ch3 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cmp(c3.chan)
  );

  tcb_channel u_ch4 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cmp(c4.chan)
  );

  ////////////////////////////////////////////////////////////////////////////
  // main output enable; break beats any set in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      main_output_enable_reg <= 1'b0;
    end else if (break_active) begin
      main_output_enable_reg <= 1'b0;
    end else if (hit(addr_i, tcb_pkg::PROT_OFFSET, wr_i)) begin
      main_output_enable_reg <= wdata_i[tcb_pkg::MOE_BIT];
    end else if (update_i && auto_output_enable_reg) begin
      main_output_enable_reg <= 1'b1;
    end
  end

  // protected fields: lock field written once, then frozen
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      auto_output_enable_reg <= 1'b0;
      break_polarity_select_reg <= 1'b0;
      break_inputs_enable_reg <= 1'b0;
      lock_reg <= tcb_pkg::LOCK_NONE;
      lock_written_reg <= 1'b0;
    end else if (hit(addr_i, tcb_pkg::PROT_OFFSET, wr_i)) begin
      lock_written_reg <= 1'b1;
      if (!lock_written_reg) begin
        lock_reg <= wdata_i[tcb_pkg::LOCK_LSB +: 2];
      end
      if (lock_reg == tcb_pkg::LOCK_NONE) begin
        auto_output_enable_reg <= wdata_i[tcb_pkg::AOE_BIT];
        break_polarity_select_reg <= wdata_i[tcb_pkg::BKP_BIT];
        break_inputs_enable_reg <= wdata_i[tcb_pkg::BKE_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      chcfg_reg <= 8'h00;
    end else if (hit(addr_i, tcb_pkg::CHCFG_OFFSET, wr_i)) begin
      chcfg_reg <= wdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: both forced idle low and released while main enable is off
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_reg <= 2'b00;
      outn_reg <= 2'b00;
      oe_reg <= 2'b00;
      noe_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        oe_reg[i] <= main_output_enable_reg && !break_active &&
                     !chcfg_reg[4*i + tcb_pkg::CFG_INPUT] && chcfg_reg[4*i + tcb_pkg::CFG_OE];
        noe_reg[i] <= main_output_enable_reg && !break_active &&
                      !chcfg_reg[4*i + tcb_pkg::CFG_INPUT] && chcfg_reg[4*i + tcb_pkg::CFG_NOE];
      end
      out_reg[0] <= c3.match && main_output_enable_reg && !break_active && chcfg_reg[tcb_pkg::CFG_OE];
      out_reg[1] <= c4.match && main_output_enable_reg && !break_active && chcfg_reg[4 + tcb_pkg::CFG_OE];
      outn_reg[0] <= !c3.match && main_output_enable_reg && !break_active && chcfg_reg[tcb_pkg::CFG_NOE];
      outn_reg[1] <= !c4.match && main_output_enable_reg && !break_active && chcfg_reg[4 + tcb_pkg::CFG_NOE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one-to-clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_status_reg <= 3'h0;
    end else begin
      for (int i = 0; i < tcb_pkg::IRQ_W; i++) begin
        if (hit(addr_i, tcb_pkg::IRQ_STATUS_OFFSET, wr_i) && wdata_i[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
      if (capture3_i && c3.input_mode) begin
        irq_status_reg[tcb_pkg::IRQ_CAP3] <= 1'b1;
      end
      if (capture4_i && c4.input_mode) begin
        irq_status_reg[tcb_pkg::IRQ_CAP4] <= 1'b1;
      end
      if (break_active && !break_active_d_reg) begin
        irq_status_reg[tcb_pkg::IRQ_BREAK] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= 3'h0;
    end else if (hit(addr_i, tcb_pkg::IRQ_MASK_OFFSET, wr_i)) begin
      irq_mask_reg <= wdata_i[2:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data valid the cycle after the strobe only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        tcb_pkg::CH3_CCR_OFFSET: rdata_reg <= {12'h000, c3.value};
        tcb_pkg::CH4_CCR_OFFSET: rdata_reg <= {12'h000, c4.value};
        tcb_pkg::PROT_OFFSET: rdata_reg <= {16'h0000, main_output_enable_reg, auto_output_enable_reg,
                                             break_polarity_select_reg, break_inputs_enable_reg,
                                             2'b00, lock_reg, 8'h00};
        tcb_pkg::CHCFG_OFFSET: rdata_reg <= {24'h00_0000, chcfg_reg};
        tcb_pkg::IRQ_STATUS_OFFSET: rdata_reg <= {29'h0000_0000, irq_status_reg};
        tcb_pkg::IRQ_MASK_OFFSET: rdata_reg <= {29'h0000_0000, irq_mask_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_reg;
  assign channel_output_o = out_reg;
  assign channel_complement_output_o = outn_reg;
  assign channel_output_oe_o = oe_reg;
  assign channel_complement_output_oe_o = noe_reg;
  assign main_output_enable_o = main_output_enable_reg;
  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_break_seen;
    break_active;
  endsequence

  // first cycle of a break, as the status edge detector sees it
  sequence s_break_starts;
    break_active && !break_active_d_reg;
  endsequence

  a_break_clears_moe: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_break_seen |=> !main_output_enable_reg)
    else $error("break did not clear main enable");
  a_break_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !break_inputs_enable_reg |-> !break_active)
    else $error("break active while disabled");
  a_auto_sets_moe: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    auto_output_enable_reg && update_i && !break_active && !wr_i |=> main_output_enable_reg)
    else $error("auto enable did not set main");
  a_no_hw_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !main_output_enable_reg && !auto_output_enable_reg && !wr_i |=> !main_output_enable_reg)
    else $error("main enable set by hardware");
  a_sw_set_moe: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit(addr_i, tcb_pkg::PROT_OFFSET, wr_i) && wdata_i[tcb_pkg::MOE_BIT] && !break_active
    |=> main_output_enable_reg)
    else $error("software set of main enable lost");
  a_aoe_locked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    lock_reg != tcb_pkg::LOCK_NONE |=> $stable(auto_output_enable_reg))
    else $error("auto enable changed while locked");
  a_idle_outputs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !main_output_enable_reg |=> oe_reg == 2'b00 && noe_reg == 2'b00 && out_reg == 2'b00)
    else $error("outputs active with main enable off");
  a_chan_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !chcfg_reg[tcb_pkg::CFG_OE] |=> !oe_reg[0])
    else $error("channel 3 driven without enable");
  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(rd_i) && $past(addr_i) == tcb_pkg::CH4_CCR_OFFSET |-> rdata_reg[31:20] == 12'h000)
    else $error("reserved compare bits nonzero");
  a_pol_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    break_inputs_enable_reg && !break_polarity_select_reg && !pin_sync2_reg[0] |-> break_active)
    else $error("active-low break missed");
  a_pol_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    break_inputs_enable_reg && break_polarity_select_reg && pin_sync2_reg[0] |-> break_active)
    else $error("active-high break missed");
  a_clkfail_break: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    break_inputs_enable_reg && pin_sync2_reg[1] |-> break_active)
    else $error("clock failure did not break");
  a_break_idles_pins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_break_seen |=> oe_reg == 2'b00 && noe_reg == 2'b00)
    else $error("pins driven during break");
  a_break_status: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_break_starts |=> irq_status_reg[tcb_pkg::IRQ_BREAK])
    else $error("break event not flagged");
  a_input_no_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    chcfg_reg[tcb_pkg::CFG_INPUT] |=> !oe_reg[0] && !noe_reg[0])
    else $error("input channel 3 driven");
  a_ch4_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !chcfg_reg[4 + tcb_pkg::CFG_OE] |=> !oe_reg[1] && !out_reg[1])
    else $error("channel 4 driven without enable");
  a_comp_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !chcfg_reg[tcb_pkg::CFG_NOE] |=> !noe_reg[0] && !outn_reg[0])
    else $error("channel 3 complement driven without enable");
  a_no_shoot_through: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (out_reg & outn_reg) == 2'b00)
    else $error("both switches of one leg on");
  a_match_drives: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    main_output_enable_reg && !break_active && chcfg_reg[tcb_pkg::CFG_OE] && c3.match |=> out_reg[0])
    else $error("channel 3 match not driven");
  a_bkp_locked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    lock_reg != tcb_pkg::LOCK_NONE |=> $stable(break_polarity_select_reg) && $stable(break_inputs_enable_reg))
    else $error("break setup changed while locked");
  a_unlocked_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    lock_reg == tcb_pkg::LOCK_NONE && hit(addr_i, tcb_pkg::PROT_OFFSET, wr_i)
    |=> auto_output_enable_reg == $past(wdata_i[tcb_pkg::AOE_BIT]))
    else $error("unprotected auto enable write lost");
  a_ch3_reserved: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(rd_i) && $past(addr_i) == tcb_pkg::CH3_CCR_OFFSET |-> rdata_reg[31:20] == 12'h000)
    else $error("reserved channel 3 bits nonzero");
endmodule
`default_nettype wire

// ### sim/tcb_power_stage.sv
`default_nettype none
module tcb_power_stage (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // gate drive from the timer
  input wire logic [1:0] hi_i,
  input wire logic [1:0] lo_i,
  input wire logic [1:0] hi_oe_i,
  input wire logic [1:0] lo_oe_i,
  // stage status
  output logic fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hi_gate;
  logic [1:0] lo_gate;
  // released gate lines sit on pull-downs, so they read low
  assign hi_gate = hi_i & hi_oe_i;
  assign lo_gate = lo_i & lo_oe_i;
  // both switches of one leg on is shoot-through, latched until reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else if ((hi_gate & lo_gate) != 2'h0) begin
      fault_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_timer_ch34_compare_and_break_output_gate.sv
`default_nettype none
module tb_timer_ch34_compare_and_break_output_gate;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [19:0] counter_i = 20'h0_0000;
  logic update_i = 1'h0;
  logic capture3_i = 1'h0;
  logic capture4_i = 1'h0;
  logic break_pin_i = 1'h0;
  logic clock_failure_monitor_i = 1'h0;
  logic [31:0] rdata_o;
  logic [1:0] ch_o, chn_o, ch_oe, chn_oe;
  logic main_output_enable, irq, fault;
  logic [31:0] rd_val;
  int n_errors = 0;
  int cmp_count = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  tcb_timer_ch34 dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .counter_i(counter_i), .update_i(update_i),
    .capture3_i(capture3_i), .capture4_i(capture4_i), .break_pin_i(break_pin_i),
    .clock_failure_monitor_i(clock_failure_monitor_i), .channel_output_o(ch_o),
    .channel_complement_output_o(chn_o), .channel_output_oe_o(ch_oe),
    .channel_complement_output_oe_o(chn_oe), .main_output_enable_o(main_output_enable), .irq_o(irq));
  tcb_power_stage stage (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hi_i(ch_o), .lo_i(chn_o),
    .hi_oe_i(ch_oe), .lo_oe_i(chn_oe), .fault_o(fault));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'h0;
  endtask
  // read data live only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'h0;
    #1;
    rd_val = rdata_o;
    chk(rd_val, exp);
  endtask
  // pulses {capture4, capture3, update} for one cycle
  task automatic events(input logic [2:0] e);
    @(posedge sys_clk_i);
    {capture4_i, capture3_i, update_i} <= e;
    @(posedge sys_clk_i);
    {capture4_i, capture3_i, update_i} <= 3'h0;
  endtask
  task automatic pin_chk(input logic [11:0] e);
    chk({22'h00_0000, main_output_enable, irq, chn_oe, ch_oe, chn_o, ch_o}, {20'h0_0000, e});
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_i <= 1'h1;
    tick(4);
    @(posedge sys_clk_i);
    rst_i <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset_values();
    rd_chk(8'h3C, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(8'h44, 32'h0000_0000);
    reg_wr(8'h60, 32'hFFFF_FFFF);
    rd_chk(8'h60, 32'h0000_0000);
  endtask
  task automatic s_compare();
    reg_wr(8'h48, 32'h0000_000C);
    reg_wr(8'h3C, 32'hFFF1_2345);
    rd_chk(8'h3C, 32'h0001_2345);
    @(posedge sys_clk_i);
    counter_i <= 20'h1_2345;
    tick(3);
    pin_chk(12'h000);
    reg_wr(8'h44, 32'h0000_8000);
    tick(3);
    pin_chk(12'h251);
    @(posedge sys_clk_i);
    counter_i <= 20'h1_2344;
    tick(3);
    pin_chk(12'h254);
  endtask
  task automatic s_shadow();
    reg_wr(8'h48, 32'h0000_00EC);
    reg_wr(8'h40, 32'h0002_0000);
    tick(3);
    chk(ch_o, 2'h2);
    events(3'h1);
    tick(3);
    chk(ch_o, 2'h0);
    rd_chk(8'h40, 32'h0002_0000);
  endtask
  task automatic s_capture();
    reg_wr(8'h50, 32'h0000_0007);
    reg_wr(8'h48, 32'h0000_0011);
    counter_i <= 20'h0_ABCD;
    events(3'h2);
    counter_i <= 20'h0_F00F;
    events(3'h4);
    reg_wr(8'h3C, 32'h0000_0001);
    reg_wr(8'h40, 32'h0000_0001);
    rd_chk(8'h3C, 32'h0000_ABCD);
    rd_chk(8'h40, 32'h0000_F00F);
    chk(irq, 1'h1);
    rd_chk(8'h4C, 32'h0000_0003);
    reg_wr(8'h4C, 32'h0000_0003);
    rd_chk(8'h4C, 32'h0000_0000);
    reg_wr(8'h50, 32'h0000_0000);
    events(3'h2);
    tick(2);
    chk(irq, 1'h0);
    reg_wr(8'h4C, 32'h0000_0001);
    reg_wr(8'h50, 32'h0000_0004);
  endtask
  task automatic s_break();
    reg_wr(8'h48, 32'h0000_00CC);
    reg_wr(8'h44, 32'h0000_F000);
    rd_chk(8'h44, 32'h0000_F000);
    chk(main_output_enable, 1'h1);
    @(posedge sys_clk_i);
    break_pin_i <= 1'h1;
    tick(4);
    chk(main_output_enable, 1'h0);
    chk({chn_oe, ch_oe}, 4'h0);
    chk(irq, 1'h1);
    reg_wr(8'h4C, 32'h0000_0004);
    events(3'h1);
    tick(3);
    chk(main_output_enable, 1'h0);
    @(posedge sys_clk_i);
    break_pin_i <= 1'h0;
    tick(4);
    chk(main_output_enable, 1'h0);
    events(3'h1);
    tick(3);
    chk(main_output_enable, 1'h1);
    @(posedge sys_clk_i);
    break_pin_i <= 1'h1;
    reg_wr(8'h44, 32'h0000_9000);
    tick(4);
    chk(main_output_enable, 1'h1);
    @(posedge sys_clk_i);
    break_pin_i <= 1'h0;
    tick(4);
    chk(main_output_enable, 1'h0);
    @(posedge sys_clk_i);
    break_pin_i <= 1'h1;
    events(3'h1);
    tick(4);
    chk(main_output_enable, 1'h0);
    @(posedge sys_clk_i);
    break_pin_i <= 1'h0;
    reg_wr(8'h44, 32'h0000_8000);
    clock_failure_monitor_i <= 1'h1;
    tick(4);
    chk(main_output_enable, 1'h1);
    @(posedge sys_clk_i);
    break_pin_i <= 1'h1;
    reg_wr(8'h44, 32'h0000_9000);
    tick(4);
    chk(main_output_enable, 1'h0);
    chk(fault, 1'h0);
    @(posedge sys_clk_i);
    clock_failure_monitor_i <= 1'h0;
  endtask
  task automatic s_lock();
    do_reset();
    reg_wr(8'h44, 32'h0000_0100);
    reg_wr(8'h44, 32'h0000_F000);
    rd_chk(8'h44, 32'h0000_8100);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    s_reset_values();
    s_compare();
    s_shadow();
    s_capture();
    s_break();
    s_lock();
    stop_test();
  end
endmodule
`default_nettype wire
